// file: shared/irt_map.svh
/*
 * Constant map of the IR remote-code transmitter: clock rate, key timing,
 * carrier limits, reset values and per-protocol symbol timing in microseconds.
 * Assumes it is included by bare name wherever these figures are needed.
 */
// Function
// R1 - Carrier frequency is settable anywhere from 30 kHz to 56 kHz.
// R2 - Carrier duty cycle is one half, one third or one quarter, nothing else.
// R3 - A protocol change loads its default carrier frequency and duty; user may override.
// R4 - Transmit repeatedly while the long press holds; stop on key release.
// R5 - Each short press advances the selected item; the selection is shown outward.
// R6 - Increment and decrement steps change only the currently selected item; the code also cuts the data fields to the new widths on a protocol step.
// R7 - Two short presses in quick succession end the function and return control.
// R8 - Japanese 48-bit frames carry manufacturer 16, system 4, product 8, function 8 bits.
// R9 - The 20-bit width-coded frame carries command 7, address 5, extended 8 bits.
// R10 - The 32-bit custom-code frame carries an 8-bit custom code and 8-bit key data.
// R11 - The address/command/mask frame carries address 5, command 8 and one mask bit.
// R12 - Carrier is gated on during frame pulses; output stays low during pauses.
`ifndef IRT_MAP_SVH
`define IRT_MAP_SVH

// Clock, key timing and FIFO depth.
`define IRT_CLOCK_KHZ 25000
`define IRT_US_CYCLES (`IRT_CLOCK_KHZ / 1000)
`define IRT_LONG_PRESS_MS 300
`define IRT_DOUBLE_MS 400
`define IRT_FIFO_DEPTH 32

// Carrier limits and reset values.
`define IRT_KHZ_MIN 8'h1E
`define IRT_KHZ_MAX 8'h38
`define IRT_RST_KHZ 8'h26

// Default carrier per protocol.
`define IRT_JP_KHZ 8'h25
`define IRT_PW_KHZ 8'h28
`define IRT_PD_KHZ 8'h26
`define IRT_ACM_KHZ 8'h26

// Japanese 48-bit pulse-distance timing.
`define IRT_JP_LEAD_M 15'h0D80
`define IRT_JP_LEAD_S 15'h06C0
`define IRT_JP_BIT_M 15'h01B0
`define IRT_JP_ONE_S 15'h0510

// 20-bit pulse-width timing.
`define IRT_PW_LEAD_M 15'h0960
`define IRT_PW_UNIT 15'h0258
`define IRT_PW_ONE_M 15'h04B0

// 32-bit custom-code timing.
`define IRT_PD_LEAD 15'h1194
`define IRT_PD_BIT_M 15'h0230
`define IRT_PD_ONE_S 15'h069A

// Address/command/mask timing.
`define IRT_ACM_BIT_M 15'h0140
`define IRT_ACM_ZERO_S 15'h02A8
`define IRT_ACM_ONE_S 15'h0690

// Pause after every frame.
`define IRT_GAP 15'h7530

`endif

// file: shared/irt_pkg.sv
/*
 * Types of the IR remote-code transmitter: protocols, duty settings, menu
 * items, framer states and the structs carried between stages.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package irt_pkg;
    typedef enum logic [1:0] {PR_JP48 = 2'h0, PR_PW20 = 2'h1, PR_PD32 = 2'h2, PR_ACM = 2'h3} irt_proto_e;
    typedef enum logic [1:0] {DU_HALF = 2'h0, DU_THIRD = 2'h1, DU_QUARTER = 2'h2} irt_duty_e;
    typedef enum logic [2:0] {
        IT_PROTO = 3'h0, IT_KHZ = 3'h1, IT_DUTY = 3'h2,
        IT_F0 = 3'h3, IT_F1 = 3'h4, IT_F2 = 3'h5, IT_F3 = 3'h6
    } irt_item_e;
    typedef enum logic [2:0] {
        FR_IDLE = 3'h0, FR_LEADM = 3'h1, FR_LEADS = 3'h2, FR_BITM = 3'h3,
        FR_BITS = 3'h4, FR_TRAIL = 3'h5, FR_GAP = 3'h6
    } irt_fr_e;
    // One envelope symbol: pulse or pause, length in microseconds.
    typedef struct packed {
        logic mark;
        logic [14:0] dur;
    } irt_sym_s;
    // Carrier and protocol setting shown to the user.
    typedef struct packed {
        irt_proto_e proto;
        logic [7:0] khz;
        irt_duty_e duty;
    } irt_cfg_s;
    // Symbol timing of one protocol.
    typedef struct packed {
        logic [14:0] lm;
        logic [14:0] ls;
        logic [14:0] m0;
        logic [14:0] m1;
        logic [14:0] s0;
        logic [14:0] s1;
        logic [14:0] tr;
        logic [5:0] nb;
    } irt_tim_s;
endpackage : irt_pkg

// file: verilog/irt_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides and a registered read port.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module irt_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic reset,
    // Filling side.
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side.
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_wr;
    logic do_rd;

    // Full refuses writes, so the source stalls rather than losing words.
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign do_wr = in_valid && in_ready;
    assign do_rd = (count != '0) && (!out_valid || out_ready);

    // Storage array.
    always_ff @(posedge clock) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and fill count.
    always_ff @(posedge clock) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

    // Registered output word; it refills as soon as it is taken.
    always_ff @(posedge clock) begin
        if (reset) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (do_rd) begin
            out_valid <= 1'b1;
            out_data <= mem[rd_ptr];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule : irt_fifo

// file: verilog/irt_transmitter.sv
/*
 * IR remote-code transmitter: key and step handling, menu of settings,
 * frame builder, symbol FIFO and carrier modulator driving the probe pin.
 * Assumes the key and step inputs are raw pins; start comes from the caller's logic.
 */
`timescale 1ns/1ps
`include "irt_map.svh"
module irt_transmitter #(
    parameter int unsigned LONG_PRESS_CYCLES = `IRT_LONG_PRESS_MS * `IRT_CLOCK_KHZ,
    parameter int unsigned DOUBLE_CYCLES = `IRT_DOUBLE_MS * `IRT_CLOCK_KHZ
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic reset,
    // Caller handshake.
    input wire logic start,
    output logic active,
    output logic exit_done,
    // Raw user pins.
    input wire logic key_pin,
    input wire logic step_up_pin,
    input wire logic step_down_pin,
    // Settings shown on the display.
    output irt_pkg::irt_item_e sel_item,
    output irt_pkg::irt_cfg_s cfg,
    output logic [3:0][15:0] fld,
    output logic tx_active,
    // Probe output toward the LED driver.
    output logic ir_out
);
    import irt_pkg::*;

    localparam logic [23:0] LONG_C = 24'(LONG_PRESS_CYCLES);
    localparam logic [23:0] DBL_C = 24'(DOUBLE_CYCLES);
    localparam logic [4:0] US_C = 5'(`IRT_US_CYCLES);

    // Data field width of each protocol, zero where the field is absent.
    function automatic logic [4:0] fw(input irt_proto_e p, input logic [1:0] i);
        logic [4:0] w;
        w = 5'h00;
        unique case (p)
            PR_JP48: w = (i == 2'h0) ? 5'h10 : (i == 2'h1) ? 5'h04 : 5'h08; // see R8
            PR_PW20: w = (i == 2'h0) ? 5'h07 : (i == 2'h1) ? 5'h05 : (i == 2'h2) ? 5'h08 : 5'h00; // see R9
            PR_PD32: w = (i[1] == 1'b0) ? 5'h08 : 5'h00; // see R10
            PR_ACM: w = (i == 2'h0) ? 5'h05 : (i == 2'h1) ? 5'h08 : (i == 2'h2) ? 5'h01 : 5'h00; // see R11
        endcase
        return w;
    endfunction : fw

    function automatic logic [15:0] wmask(input logic [4:0] w);
        return 16'hFFFF >> (5'h10 - w);
    endfunction : wmask

    function automatic logic [7:0] def_khz(input irt_proto_e p);
        logic [7:0] k;
        k = `IRT_PD_KHZ;
        unique case (p)
            PR_JP48: k = `IRT_JP_KHZ;
            PR_PW20: k = `IRT_PW_KHZ;
            PR_PD32: k = `IRT_PD_KHZ;
            PR_ACM: k = `IRT_ACM_KHZ;
        endcase
        return k;
    endfunction : def_khz

    function automatic irt_duty_e def_duty(input irt_proto_e p);
        return (p == PR_PW20) ? DU_QUARTER : DU_THIRD;
    endfunction : def_duty

    // Next menu item; field items that the protocol lacks are skipped.
    function automatic irt_item_e adv_item(input irt_item_e it, input irt_proto_e p);
        irt_item_e n;
        n = IT_PROTO;
        unique case (it)
            IT_PROTO: n = IT_KHZ;
            IT_KHZ: n = IT_DUTY;
            IT_DUTY: n = IT_F0;
            IT_F0: n = (fw(p, 2'h1) != 5'h00) ? IT_F1 : IT_PROTO;
            IT_F1: n = (fw(p, 2'h2) != 5'h00) ? IT_F2 : IT_PROTO;
            IT_F2: n = (fw(p, 2'h3) != 5'h00) ? IT_F3 : IT_PROTO;
            IT_F3: n = IT_PROTO;
            default: n = IT_PROTO;
        endcase
        return n;
    endfunction : adv_item

    function automatic irt_tim_s timing(input irt_proto_e p);
        irt_tim_s t;
        t = '0;
        unique case (p)
            PR_JP48: t = '{`IRT_JP_LEAD_M, `IRT_JP_LEAD_S, `IRT_JP_BIT_M, `IRT_JP_BIT_M,
                           `IRT_JP_BIT_M, `IRT_JP_ONE_S, `IRT_JP_BIT_M, 6'h30};
            PR_PW20: t = '{`IRT_PW_LEAD_M, `IRT_PW_UNIT, `IRT_PW_UNIT, `IRT_PW_ONE_M,
                           `IRT_PW_UNIT, `IRT_PW_UNIT, 15'h0000, 6'h14};
            PR_PD32: t = '{`IRT_PD_LEAD, `IRT_PD_LEAD, `IRT_PD_BIT_M, `IRT_PD_BIT_M,
                           `IRT_PD_BIT_M, `IRT_PD_ONE_S, `IRT_PD_BIT_M, 6'h20};
            PR_ACM: t = '{15'h0000, 15'h0000, `IRT_ACM_BIT_M, `IRT_ACM_BIT_M,
                          `IRT_ACM_ZERO_S, `IRT_ACM_ONE_S, `IRT_ACM_BIT_M, 6'h0F};
        endcase
        return t;
    endfunction : timing

    // Frame bits, sent from bit 0 upward.
    function automatic logic [47:0] frame_bits(input irt_proto_e p, input logic [3:0][15:0] f);
        logic [47:0] b;
        logic [3:0] par;
        par = f[0][3:0] ^ f[0][7:4] ^ f[0][11:8] ^ f[0][15:12];
        b = '0;
        unique case (p)
            PR_JP48: b = {{f[1][3:0], par} ^ f[2][7:0] ^ f[3][7:0], f[3][7:0], f[2][7:0],
                          f[1][3:0], par, f[0]}; // see R8
            PR_PW20: b = {28'h0000000, f[2][7:0], f[1][4:0], f[0][6:0]}; // see R9
            PR_PD32: b = {16'h0000, ~f[1][7:0], f[1][7:0], f[0][7:0], f[0][7:0]}; // see R10
            PR_ACM: b = {33'h000000000, 1'b1, f[2][0], f[1][7:0], f[0][4:0]}; // see R11
        endcase
        return b;
    endfunction : frame_bits

    logic [2:0] pin_meta;
    logic [2:0] pin_s;
    logic [2:0] pin_d;
    logic key_s;
    logic key_rise;
    logic key_fall;
    logic step_up;
    logic step_any;
    logic [23:0] press_cnt;
    logic long_hit;
    logic short_ev;
    logic tx_req;
    logic dbl_open;
    logic [23:0] dbl_cnt;
    irt_proto_e next_proto;
    logic [1:0] fidx;
    irt_fr_e fr_state;
    irt_tim_s tim;
    logic [47:0] frame;
    logic [5:0] bit_cnt;
    logic push_valid;
    irt_sym_s push;
    logic push_ready;
    logic pop_valid;
    irt_sym_s pop;
    logic mod_busy;
    logic mod_mark;
    logic [14:0] rem;
    logic [4:0] us_cnt;
    logic [9:0] car_period;
    logic [9:0] car_high;
    logic [9:0] car_cnt;

    // Two-stage synchronisers for the pins, then one more stage for edges.
    always_ff @(posedge clock) begin
        if (reset) begin
            pin_meta <= 3'h0;
            pin_s <= 3'h0;
            pin_d <= 3'h0;
        end else begin
            pin_meta <= {step_down_pin, step_up_pin, key_pin};
            pin_s <= pin_meta;
            pin_d <= pin_s;
        end
    end

    assign key_s = pin_s[0];
    assign key_rise = pin_s[0] && !pin_d[0];
    assign key_fall = !pin_s[0] && pin_d[0];
    assign step_up = pin_s[1] && !pin_d[1];
    assign step_any = step_up || (pin_s[2] && !pin_d[2]);
    assign next_proto = step_up ? irt_proto_e'(cfg.proto + 2'h1) : irt_proto_e'(cfg.proto - 2'h1);
    assign fidx = 2'(sel_item - IT_F0);

    // Press timing: a release before the long mark is a short press.
    always_ff @(posedge clock) begin
        if (reset) begin
            press_cnt <= 24'h000000;
            long_hit <= 1'b0;
            short_ev <= 1'b0;
        end else begin
            short_ev <= key_fall && !long_hit;
            if (key_rise) begin
                press_cnt <= 24'h000000;
                long_hit <= 1'b0;
            end else if (key_s && !long_hit) begin
                long_hit <= (press_cnt == LONG_C - 24'h000001);
                press_cnt <= press_cnt + 24'h000001;
            end
        end
    end

    // Transmit request follows the held long press and drops on release.
    always_ff @(posedge clock) begin
        if (reset) begin
            tx_req <= 1'b0;
        end else begin
            tx_req <= active && key_s && long_hit; // see R4
        end
    end

    assign tx_active = tx_req;

    // Menu: a short press advances, a second one inside the window exits.
    always_ff @(posedge clock) begin
        if (reset) begin
            active <= 1'b0;
            exit_done <= 1'b0;
            sel_item <= IT_PROTO;
            dbl_open <= 1'b0;
            dbl_cnt <= 24'h000000;
        end else begin
            exit_done <= 1'b0;
            if (start && !active) begin
                active <= 1'b1;
                sel_item <= IT_PROTO;
                dbl_open <= 1'b0;
            end else if (active && short_ev && dbl_open) begin
                active <= 1'b0; // see R7
                exit_done <= 1'b1;
                dbl_open <= 1'b0;
            end else if (active && short_ev) begin
                sel_item <= adv_item(sel_item, cfg.proto); // see R5
                dbl_open <= 1'b1;
                dbl_cnt <= 24'h000000;
            end else if (dbl_open) begin
                dbl_open <= (dbl_cnt != DBL_C - 24'h000001);
                dbl_cnt <= dbl_cnt + 24'h000001;
            end
        end
    end

    // Steps change only the selected item, except that a new protocol loads its carrier and cuts the fields to its widths.
    always_ff @(posedge clock) begin
        if (reset) begin
            cfg <= '{PR_PD32, `IRT_RST_KHZ, DU_THIRD};
            fld <= '0;
        end else if (active && step_any) begin
            unique case (sel_item) // see R6
                IT_PROTO: begin
                    cfg.proto <= next_proto;
                    cfg.khz <= def_khz(next_proto); // see R3
                    cfg.duty <= def_duty(next_proto);
                    for (int k = 0; k < 4; k++) begin
                        fld[k] <= fld[k] & wmask(fw(next_proto, 2'(k)));
                    end
                end
                IT_KHZ: begin
                    if (step_up && cfg.khz < `IRT_KHZ_MAX) begin
                        cfg.khz <= cfg.khz + 8'h01; // see R1
                    end else if (!step_up && cfg.khz > `IRT_KHZ_MIN) begin
                        cfg.khz <= cfg.khz - 8'h01;
                    end
                end
                IT_DUTY: begin
                    unique case (cfg.duty) // see R2
                        DU_HALF: cfg.duty <= step_up ? DU_THIRD : DU_QUARTER;
                        DU_THIRD: cfg.duty <= step_up ? DU_QUARTER : DU_HALF;
                        DU_QUARTER: cfg.duty <= step_up ? DU_HALF : DU_THIRD;
                        default: cfg.duty <= DU_HALF;
                    endcase
                end
                IT_F0, IT_F1, IT_F2, IT_F3: begin
                    fld[fidx] <= (step_up ? fld[fidx] + 16'h0001 : fld[fidx] - 16'h0001)
                                 & wmask(fw(cfg.proto, fidx));
                end
                default: begin
                end
            endcase
        end
    end

    // Symbol offered to the FIFO in each framer state.
    always_comb begin
        push_valid = 1'b1;
        push = '{1'b0, 15'h0000};
        unique case (fr_state)
            FR_IDLE: push_valid = 1'b0;
            FR_LEADM: push = '{1'b1, tim.lm};
            FR_LEADS: push = '{1'b0, tim.ls};
            FR_BITM: push = '{1'b1, frame[0] ? tim.m1 : tim.m0};
            FR_BITS: push = '{1'b0, frame[0] ? tim.s1 : tim.s0};
            FR_TRAIL: push = '{1'b1, tim.tr};
            FR_GAP: push = '{1'b0, `IRT_GAP};
            default: push_valid = 1'b0;
        endcase
    end

    // Framer: one whole frame per pass, repeated while the request stands.
    always_ff @(posedge clock) begin
        if (reset) begin
            fr_state <= FR_IDLE;
            tim <= '0;
            frame <= 48'h000000000000;
            bit_cnt <= 6'h00;
        end else if (fr_state == FR_IDLE) begin
            if (tx_req) begin
                tim <= timing(cfg.proto);
                frame <= frame_bits(cfg.proto, fld);
                bit_cnt <= 6'h00;
                fr_state <= (cfg.proto == PR_ACM) ? FR_BITM : FR_LEADM; // Only this frame type has no leader.
            end
        end else if (push_ready) begin
            unique case (fr_state)
                FR_LEADM: fr_state <= FR_LEADS;
                FR_LEADS: fr_state <= FR_BITM;
                FR_BITM: fr_state <= FR_BITS;
                FR_BITS: begin
                    frame <= frame >> 1;
                    bit_cnt <= bit_cnt + 6'h01;
                    if (bit_cnt == tim.nb - 6'h01) begin
                        fr_state <= (tim.tr != 15'h0000) ? FR_TRAIL : FR_GAP;
                    end else begin
                        fr_state <= FR_BITM;
                    end
                end
                FR_TRAIL: fr_state <= FR_GAP;
                FR_GAP: fr_state <= FR_IDLE;
                default: fr_state <= FR_IDLE;
            endcase
        end
    end

    // The FIFO decouples frame building from the slow envelope timing.
    irt_fifo #(
        .WIDTH($bits(irt_sym_s)),
        .DEPTH(`IRT_FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .reset(reset),
        .in_valid(push_valid),
        .in_data(push),
        .in_ready(push_ready),
        .out_valid(pop_valid),
        .out_data(pop),
        .out_ready(!mod_busy)
    );

    // Modulator: plays one symbol at a time in microsecond ticks.
    always_ff @(posedge clock) begin
        if (reset) begin
            mod_busy <= 1'b0;
            mod_mark <= 1'b0;
            rem <= 15'h0000;
            us_cnt <= 5'h00;
        end else if (!mod_busy) begin
            mod_mark <= 1'b0;
            if (pop_valid) begin
                mod_busy <= 1'b1;
                mod_mark <= pop.mark;
                rem <= pop.dur;
                us_cnt <= 5'h00;
            end
        end else if (us_cnt == US_C - 5'h01) begin
            us_cnt <= 5'h00;
            rem <= rem - 15'h0001;
            mod_busy <= (rem != 15'h0001);
        end else begin
            us_cnt <= us_cnt + 5'h01;
        end
    end

    // Carrier period and high time; the period settles a cycle and the high time two cycles after a frequency change.
    always_ff @(posedge clock) begin
        if (reset) begin
            car_period <= 10'h000;
            car_high <= 10'h000;
        end else begin
            car_period <= 10'(`IRT_CLOCK_KHZ / cfg.khz); // see R1
            unique case (cfg.duty) // see R2
                DU_THIRD: car_high <= car_period / 10'h003;
                DU_QUARTER: car_high <= car_period >> 2;
                default: car_high <= car_period >> 1;
            endcase
        end
    end

    // Carrier restarts at each pulse so every pulse opens with a full high phase.
    always_ff @(posedge clock) begin
        if (reset || (!mod_busy && pop_valid) || car_cnt >= car_period - 10'h001) begin
            car_cnt <= 10'h000;
        end else begin
            car_cnt <= car_cnt + 10'h001;
        end
    end

    // Envelope gate: carrier only inside pulses, low in pauses.
    always_ff @(posedge clock) begin
        if (reset) begin
            ir_out <= 1'b0;
        end else begin
            ir_out <= mod_busy && mod_mark && (car_cnt < car_high); // see R12
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence seq_exit;
        exit_done ##1 (!exit_done && !active);
    endsequence

    sequence seq_long_held;
        (active && key_s && !key_rise && !long_hit && press_cnt == LONG_C - 24'h000001) ##1 (key_s && active);
    endsequence

    chk_carrier_range: assert property (cfg.khz >= 8'h1E && cfg.khz <= 8'h38) // see R1
        else $error("carrier frequency out of range");
    chk_duty_legal: assert property (car_high == (($past(cfg.duty) == DU_QUARTER) ? $past(car_period) >> 2 : // see R2
        ($past(cfg.duty) == DU_THIRD) ? $past(car_period) / 10'h003 : $past(car_period) >> 1))
        else $error("carrier high time does not match the duty setting");
    chk_proto_default: assert property ($changed(cfg.proto) |-> // see R3
        cfg.khz == def_khz(cfg.proto) && cfg.duty == def_duty(cfg.proto))
        else $error("protocol change did not load carrier defaults");
    chk_tx_start: assert property (seq_long_held |=> tx_req) // see R4
        else $error("long press did not start transmission");
    chk_tx_stop: assert property ($fell(key_s) |=> !tx_req ##1 (fr_state != FR_LEADM || $past(fr_state) != FR_IDLE)) // see R4
        else $error("transmission continued after release");
    chk_item_adv: assert property (active && short_ev && !dbl_open && !start |=> sel_item != $past(sel_item)) // see R5
        else $error("short press did not advance selection");
    chk_step_only_sel: assert property (active && step_any && sel_item != IT_PROTO |=> $stable(cfg.proto)) // see R6
        else $error("step changed an unselected item");
    chk_double_exit: assert property (active && short_ev && dbl_open && !start |=> seq_exit) // see R7
        else $error("second short press did not exit");
    chk_field_width: assert property ((fld[0] & ~wmask(fw(cfg.proto, 2'h0))) == 16'h0000 && // see R8, see R9
        (fld[1] & ~wmask(fw(cfg.proto, 2'h1))) == 16'h0000 && (fld[2] & ~wmask(fw(cfg.proto, 2'h2))) == 16'h0000) // see R10, see R11
        else $error("data field exceeds protocol width");
    chk_pause_low: assert property (!(mod_busy && mod_mark) |=> !ir_out) // see R12
        else $error("output active during pause");
endmodule : irt_transmitter

// file: test/irt_led_model.sv
/* Model of the IR LED driver: records the length of the last completed high run of the probe output.
 * Assumes the probe output is registered on the rising clock edge. */
`timescale 1ns/1ps
module irt_led_model (
    // Clock, reset and probe input.
    input wire logic clock,
    input wire logic reset,
    input wire logic ir_out,
    // Measured carrier high time in clocks.
    output logic [15:0] hi_len
);
    logic [15:0] run;
    // A run is recorded when it ends; the last burst of a pulse may be cut short, so read it inside long pulses.
    always_ff @(posedge clock) begin
        if (reset) begin
            run <= 16'h0000;
            hi_len <= 16'h0000;
        end else if (ir_out) begin
            run <= run + 16'h0001;
        end else begin
            if (run != 16'h0000) begin
                hi_len <= run;
            end
            run <= 16'h0000;
        end
    end
endmodule : irt_led_model

// file: test/irt_transmitter_tb_top.sv
/* Self-checking bench of the IR remote-code transmitter, driving keys and steps as a user would.
 * Assumes the shortened key timings set below and the LED driver model on the probe output. */
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module irt_transmitter_tb_top;
    import irt_pkg::*;
    logic clock = 0, reset = 1, start = 0, key_pin = 0, up = 0, dn = 0;
    logic active, exit_done, tx_active, ir_out;
    irt_item_e sel_item;
    irt_cfg_s cfg;
    logic [3:0][15:0] fld;
    logic [15:0] hi_len;
    int failures = 0;
    int num_checks = 0;
    irt_cfg_s exp_cfg [3] = '{'{PR_ACM, 8'h26, DU_THIRD}, '{PR_JP48, 8'h25, DU_THIRD}, '{PR_PW20, 8'h28, DU_QUARTER}};
    irt_transmitter #(.LONG_PRESS_CYCLES(20), .DOUBLE_CYCLES(60)) irt_transmitter_inst (.clock(clock),
        .reset(reset), .start(start), .active(active), .exit_done(exit_done), .key_pin(key_pin),
        .step_up_pin(up), .step_down_pin(dn), .sel_item(sel_item), .cfg(cfg), .fld(fld),
        .tx_active(tx_active), .ir_out(ir_out));
    irt_led_model irt_led_model_inst (.clock(clock), .reset(reset), .ir_out(ir_out), .hi_len(hi_len));
    // Clock of 40 ns period.
    initial forever #20 clock = ~clock;
    task automatic wait_n(input int n);
        repeat (n) @(posedge clock);
    endtask : wait_n
    // Presses are spaced beyond the double-press window unless a gap says otherwise.
    task automatic press(input int hold, input int gap);
        key_pin <= 1'b1;
        wait_n(hold);
        key_pin <= 1'b0;
        wait_n(gap);
    endtask : press
    task automatic step(input logic dir, input int n);
        repeat (n) begin
            if (dir) up <= 1'b1;
            else dn <= 1'b1;
            wait_n(3);
            up <= 1'b0;
            dn <= 1'b0;
            wait_n(3);
        end
        wait_n(4);
    endtask : step
    task automatic close_out();
        $display("Checks %0d, failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    // Watchdog well beyond the few thousand cycles the tests take.
    initial begin
        wait_n(20000);
        failures++;
        close_out();
    end
    // Main sequence of user actions.
    initial begin
        logic seen;
        seen = 1'b0;
        wait_n(16);
        reset <= 1'b0;
        wait_n(2);
        `CHK(cfg, irt_cfg_s'{PR_PD32, 8'h26, DU_THIRD})
        start <= 1'b1;
        wait_n(1);
        start <= 1'b0;
        wait_n(2);
        `CHK(active, 1'b1)
        for (int i = 0; i < 3; i++) begin
            step(1'b1, 1);
            `CHK(cfg, exp_cfg[i])
        end
        press(5, 80);
        `CHK(sel_item, IT_KHZ)
        step(1'b0, 11);
        `CHK(cfg.khz, 8'h1E)
        step(1'b1, 27);
        `CHK(cfg.khz, 8'h38)
        `CHK(cfg.proto, PR_PW20)
        press(5, 80);
        `CHK(sel_item, IT_DUTY)
        step(1'b1, 1);
        `CHK(cfg.duty, DU_HALF)
        `CHK(cfg.khz, 8'h38)
        press(5, 80);
        step(1'b0, 1);
        `CHK(fld[0], 16'h007F)
        // Long press: at 56 kHz the half-duty high time is 446 / 2 clocks.
        key_pin <= 1'b1;
        wait_n(3000);
        `CHK(tx_active, 1'b1)
        `CHK(hi_len, 16'h00DF)
        key_pin <= 1'b0;
        wait_n(10);
        `CHK(tx_active, 1'b0)
        press(5, 10);
        press(5, 0);
        repeat (30) begin
            @(posedge clock);
            if (exit_done === 1'b1) seen = 1'b1;
        end
        `CHK(seen, 1'b1)
        `CHK(active, 1'b0)
        // Re-enter and walk the protocols: field 0 keeps 7 bits, then is cut to each new width.
        start <= 1'b1;
        wait_n(1);
        start <= 1'b0;
        wait_n(2);
        `CHK(sel_item, IT_PROTO)
        step(1'b1, 1);
        `CHK(fld[0], 16'h007F)
        step(1'b1, 1);
        `CHK(fld[0], 16'h001F)
        step(1'b1, 1);
        `CHK(fld[0], 16'h001F)
        `CHK(cfg, exp_cfg[1])
        close_out();
    end
endmodule : irt_transmitter_tb_top
